// ==== logic/pieb_map.svh ====
// Purpose: register map and field positions of the interrupt enable bank
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes: all figures as `define macros
`ifndef PIEB_MAP_SVH
`define PIEB_MAP_SVH
`define PIEB_OFF_EN1 12'h000
`define PIEB_OFF_EN2 12'h004
`define PIEB_OFF_EN3 12'h008
`define PIEB_OFF_CTRL 12'h00c
`define PIEB_OFF_FLAG 12'h010
`define PIEB_OFF_STAT 12'h014
`define PIEB_OFF_MASK 12'h018
`define PIEB_EN_RESET 8'h00
`define PIEB_EN2_WMASK 8'hfb
`define PIEB_EN2_RSVD_BIT 4
`define PIEB_EN2_UNIMP_BIT 2
`define PIEB_EN1_PORT_BIT 7
`define PIEB_CTRL_GLOBAL_BIT 0
`define PIEB_CTRL_GROUP_BIT 1
`define PIEB_CTRL_PRIO_BIT 2
`define PIEB_CTRL_RESET 3'h0
`define PIEB_RESP_OKAY 2'b00
`define PIEB_RESP_SLVERR 2'b10
`endif

// ==== logic/pieb_pkg.sv ====
// Purpose: shared types of the interrupt enable bank
// Assumes: nothing beyond the map header
// Notes: types only
package pieb_pkg;
   typedef logic [7:0] pieb_byte_t;
   typedef enum logic [1:0] {
      PIEB_IDLE = 2'b00,
      PIEB_BUSY = 2'b01,
      PIEB_RESP = 2'b11
   } pieb_wr_state_t;
endpackage

// ==== logic/pieb_gate.sv ====
// Purpose: combine flags, enables and group/global enables into requests
// Assumes: flags synchronous to aclk
// Notes: registered request outputs
`timescale 1ns/1ps
`include "pieb_map.svh"
module pieb_gate
   import pieb_pkg::*;
#(
   parameter int NSRC = 24
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [NSRC-1:0] flags,
   input wire logic [NSRC-1:0] enables,
   input wire logic global_en,
   input wire logic group_en,
   input wire logic prio_en,
   output logic [NSRC-1:0] req,
   output logic any_req
);
   logic [NSRC-1:0] req_d;
   logic [NSRC-1:0] req_q;
   logic any_d;
   logic any_q;

   always_comb begin
      if (global_en && (prio_en || group_en)) begin
         req_d = flags & enables;
      end else begin
         req_d = '0;
      end
      any_d = |req_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_q <= '0;
         any_q <= 1'b0;
      end else if (ce) begin
         req_q <= req_d;
         any_q <= any_d;
      end
   end

   assign req = req_q;
   assign any_req = any_q;

   a_group_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && !prio_en && !group_en |=> req_q == '0)
      else $error("request passed without group enable");
   a_req_cause: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && global_en && group_en |=> req_q == $past(flags & enables))
      else $error("request does not follow flags and enables");
endmodule // pieb_gate

// ==== logic/pieb_axil.sv ====
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: 32-bit data, register word addresses
// Notes: write answers one cycle after both address and data are held
`timescale 1ns/1ps
`include "pieb_map.svh"
module pieb_axil
   import pieb_pkg::*;
#(
   parameter int AW = 12
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [AW-1:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [AW-1:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   output logic wr_stb,
   output logic [AW-1:0] wr_addr,
   output logic [7:0] wr_data,
   input wire logic wr_err,
   output logic [AW-1:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire logic rd_err
);
   logic aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [AW-1:0] awa_q, awa_d, ara_q, ara_d;
   logic [7:0] wd_q, wd_d;
   logic bv_q, bv_d, rv_q, rv_d, stb_q, stb_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;
   logic [31:0] rd_q, rd_d;
   logic rd_pend_q, rd_pend_d;
   logic lane_q, lane_d;
   logic awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;

   always_comb begin
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      awa_d = awa_q;
      wd_d = wd_q;
      lane_d = lane_q;
      bv_d = bv_q;
      br_d = br_q;
      stb_d = 1'b0;
      if (s_awvalid && !aw_have_q && !bv_q) begin
         aw_have_d = 1'b1;
         awa_d = s_awaddr;
      end
      if (s_wvalid && !w_have_q && !bv_q) begin
         w_have_d = 1'b1;
         wd_d = s_wdata[7:0];
         lane_d = s_wstrb[0];
      end
      if (aw_have_q && w_have_q) begin
         // lane 0 off: answer the write but leave the register alone
         stb_d = lane_q;
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bv_d = 1'b1;
         br_d = wr_err ? `PIEB_RESP_SLVERR : `PIEB_RESP_OKAY;
      end else if (bv_q && s_bready) begin
         bv_d = 1'b0;
      end
      awrdy_d = !aw_have_d && !bv_d;
      wrdy_d = !w_have_d && !bv_d;
      ara_d = ara_q;
      rv_d = rv_q;
      rr_d = rr_q;
      rd_d = rd_q;
      rd_pend_d = rd_pend_q;
      if (s_arvalid && !rd_pend_q && !rv_q) begin
         ara_d = s_araddr;
         rd_pend_d = 1'b1;
      end else if (rd_pend_q) begin
         rd_pend_d = 1'b0;
         rv_d = 1'b1;
         rd_d = {24'h000000, rd_data};
         rr_d = rd_err ? `PIEB_RESP_SLVERR : `PIEB_RESP_OKAY;
      end else if (rv_q && s_rready) begin
         rv_d = 1'b0;
      end
      arrdy_d = !rd_pend_d && !rv_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awa_q <= '0;
         wd_q <= 8'h00;
         bv_q <= 1'b0;
         br_q <= 2'b00;
         stb_q <= 1'b0;
         ara_q <= '0;
         rv_q <= 1'b0;
         rr_q <= 2'b00;
         rd_q <= 32'h00000000;
         rd_pend_q <= 1'b0;
         lane_q <= 1'b0;
         awrdy_q <= 1'b1;
         wrdy_q <= 1'b1;
         arrdy_q <= 1'b1;
      end else if (ce) begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         bv_q <= bv_d;
         br_q <= br_d;
         stb_q <= stb_d;
         ara_q <= ara_d;
         rv_q <= rv_d;
         rr_q <= rr_d;
         rd_q <= rd_d;
         rd_pend_q <= rd_pend_d;
         lane_q <= lane_d;
         awrdy_q <= awrdy_d;
         wrdy_q <= wrdy_d;
         arrdy_q <= arrdy_d;
      end
   end

   assign s_awready = awrdy_q;
   assign s_wready = wrdy_q;
   assign s_bvalid = bv_q;
   assign s_bresp = br_q;
   assign s_arready = arrdy_q;
   assign s_rvalid = rv_q;
   assign s_rresp = rr_q;
   assign s_rdata = rd_q;
   assign wr_stb = stb_q;
   assign wr_addr = awa_q;
   assign wr_data = wd_q;
   assign rd_addr = ara_q;
endmodule // pieb_axil

// ==== logic/pieb_top.sv ====
// Purpose: peripheral interrupt enable bank with AXI4-Lite access
// Assumes: single clock aclk, synchronous active-low reset
// Notes: rules of operation below
// Operation
// - with priority off, enables need the group enable set
// - three separate per-source enable registers
// - register one bits: port, converter, rx, tx, sync, capcmp1, t2, t1
// - enable bit 1 permits its source, 0 blocks it
// - parallel port enable exists only in large package internal mode
// - register two bits: oscfail, comparator, ethernet, rsvd, coll, -, t3, cc2
// - unimplemented bit of register two ignores writes, reads zero
// - timer 1 enable gates overflow only, timer 2 gates match only
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "pieb_map.svh"
module pieb_top
   import pieb_pkg::*;
#(
   parameter bit PORT_PRESENT = 1'b1,
   parameter int AW = 12
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [AW-1:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [AW-1:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   input wire logic [23:0] src_flags,
   output logic [23:0] irq_req,
   output logic irq_core,
   output logic irq
);
   logic wr_stb, wr_err, rd_err;
   logic [AW-1:0] wr_addr, rd_addr;
   logic [7:0] wr_data, rd_data;
   pieb_byte_t en1_q, en1_d, en2_q, en2_d, en3_q, en3_d;
   logic [2:0] ctrl_q, ctrl_d;
   logic [2:0] stat_q, stat_d, mask_q, mask_d;
   logic [23:0] gate_en;
   logic any_req, any_prev_q, any_prev_d, irq_q, irq_d;

   ////////////////////////////////////////////////////////////////////////
   pieb_axil #(.AW(AW)) u_bus (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
      .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
      .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
      .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
      .s_rvalid(s_rvalid), .s_rready(s_rready),
      .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
      .wr_err(wr_err), .rd_addr(rd_addr), .rd_data(rd_data),
      .rd_err(rd_err)
   );

   function automatic logic known_addr(input logic [AW-1:0] a);
      return a == AW'(`PIEB_OFF_EN1) || a == AW'(`PIEB_OFF_EN2) ||
         a == AW'(`PIEB_OFF_EN3) || a == AW'(`PIEB_OFF_CTRL) ||
         a == AW'(`PIEB_OFF_FLAG) || a == AW'(`PIEB_OFF_STAT) ||
         a == AW'(`PIEB_OFF_MASK);
   endfunction

   assign wr_err = !known_addr(wr_addr);
   assign rd_err = !known_addr(rd_addr);

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      en1_d = en1_q;
      en2_d = en2_q;
      en3_d = en3_q;
      ctrl_d = ctrl_q;
      mask_d = mask_q;
      if (wr_stb) begin
         if (wr_addr == AW'(`PIEB_OFF_EN1)) begin
            en1_d = wr_data;
            en1_d[`PIEB_EN1_PORT_BIT] = PORT_PRESENT &
               wr_data[`PIEB_EN1_PORT_BIT];
         end else if (wr_addr == AW'(`PIEB_OFF_EN2)) begin
            en2_d = wr_data & `PIEB_EN2_WMASK;
         end else if (wr_addr == AW'(`PIEB_OFF_EN3)) begin
            en3_d = wr_data;
         end else if (wr_addr == AW'(`PIEB_OFF_CTRL)) begin
            ctrl_d = wr_data[2:0];
         end else if (wr_addr == AW'(`PIEB_OFF_MASK)) begin
            mask_d = wr_data[2:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      if (rd_addr == AW'(`PIEB_OFF_EN1)) begin
         rd_data = en1_q;
      end else if (rd_addr == AW'(`PIEB_OFF_EN2)) begin
         rd_data = en2_q;
      end else if (rd_addr == AW'(`PIEB_OFF_EN3)) begin
         rd_data = en3_q;
      end else if (rd_addr == AW'(`PIEB_OFF_CTRL)) begin
         rd_data = {5'h00, ctrl_q};
      end else if (rd_addr == AW'(`PIEB_OFF_FLAG)) begin
         rd_data = {7'h00, any_req};
      end else if (rd_addr == AW'(`PIEB_OFF_STAT)) begin
         rd_data = {5'h00, stat_q};
      end else if (rd_addr == AW'(`PIEB_OFF_MASK)) begin
         rd_data = {5'h00, mask_q};
      end else begin
         rd_data = 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // one enable bit per source
   assign gate_en = {en3_q, en2_q, en1_q};

   pieb_gate #(.NSRC(24)) u_gate (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .flags(src_flags), .enables(gate_en),
      .global_en(ctrl_q[`PIEB_CTRL_GLOBAL_BIT]),
      .group_en(ctrl_q[`PIEB_CTRL_GROUP_BIT]),
      .prio_en(ctrl_q[`PIEB_CTRL_PRIO_BIT]),
      .req(irq_req), .any_req(any_req)
   );

   ////////////////////////////////////////////////////////////////////////
   // status bit 0 request rise, 1 request fall, 2 write to unmapped
   always_comb begin
      any_prev_d = any_req;
      stat_d = stat_q;
      if (wr_stb && wr_addr == AW'(`PIEB_OFF_STAT)) begin
         stat_d = stat_q & ~wr_data[2:0];
      end
      if (any_req && !any_prev_q) begin
         stat_d[0] = 1'b1;
      end
      if (!any_req && any_prev_q) begin
         stat_d[1] = 1'b1;
      end
      if (wr_stb && wr_err) begin
         stat_d[2] = 1'b1;
      end
      irq_d = |(stat_d & mask_d);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en1_q <= `PIEB_EN_RESET;
         en2_q <= `PIEB_EN_RESET;
         en3_q <= `PIEB_EN_RESET;
         ctrl_q <= `PIEB_CTRL_RESET;
         mask_q <= 3'h0;
      end else if (ce) begin
         en1_q <= en1_d;
         en2_q <= en2_d;
         en3_q <= en3_d;
         ctrl_q <= ctrl_d;
         mask_q <= mask_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q <= 3'h0;
         any_prev_q <= 1'b0;
         irq_q <= 1'b0;
      end else if (ce) begin
         stat_q <= stat_d;
         any_prev_q <= any_prev_d;
         irq_q <= irq_d;
      end
   end

   assign irq_core = any_req;
   assign irq = irq_q;

   ////////////////////////////////////////////////////////////////////////
   // unimplemented bit reads zero
   a_unimp_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      en2_q[`PIEB_EN2_UNIMP_BIT] == 1'b0)
      else $error("unimplemented enable bit set");
   a_port_absent: assert property (@(posedge aclk) disable iff (!aresetn)
      !PORT_PRESENT |-> !en1_q[`PIEB_EN1_PORT_BIT])
      else $error("absent port enable set");
   a_en1_write: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && wr_stb && wr_addr == AW'(`PIEB_OFF_EN1) |=>
      en1_q[6:0] == $past(wr_data[6:0]))
      else $error("register one write lost");
   a_en2_write: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && wr_stb && wr_addr == AW'(`PIEB_OFF_EN2) |=>
      en2_q == ($past(wr_data) & 8'hfb))
      else $error("register two write wrong");
   a_timer1_block: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && !en1_q[0] |=> !irq_req[0])
      else $error("disabled timer one requested");
   a_en3_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && !(wr_stb && wr_addr == AW'(`PIEB_OFF_EN3)) |=> $stable(en3_q))
      else $error("register three changed without write");
   // timer two follows own flag only
   a_timer2_own: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && !src_flags[1] |=> !irq_req[1])
      else $error("timer two request without its flag");
   a_core_line: assert property (@(posedge aclk) disable iff (!aresetn)
      irq_core == |irq_req)
      else $error("core line disagrees with requests");
   a_port_write: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ce && wr_stb && wr_addr == AW'(`PIEB_OFF_EN1) |=>
      en1_q[`PIEB_EN1_PORT_BIT] ==
      (PORT_PRESENT && $past(wr_data[`PIEB_EN1_PORT_BIT])))
      else $error("port enable write wrong");
   a_en1_hold: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ce && !(wr_stb && wr_addr == AW'(`PIEB_OFF_EN1)) |=> $stable(en1_q))
      else $error("register one changed without write");
   a_en2_hold: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ce && !(wr_stb && wr_addr == AW'(`PIEB_OFF_EN2)) |=> $stable(en2_q))
      else $error("register two changed without write");
   a_en3_write: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ce && wr_stb && wr_addr == AW'(`PIEB_OFF_EN3) |=>
      en3_q == $past(wr_data))
      else $error("register three write lost");
   a_unimp_read: assert property (
      @(posedge aclk) disable iff (!aresetn)
      rd_addr == AW'(`PIEB_OFF_EN2) |->
      rd_data[`PIEB_EN2_UNIMP_BIT] == 1'b0)
      else $error("unimplemented bit read as one");
   // enabled timer one passes its flag
   a_timer1_pass: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ce && en1_q[0] && src_flags[0] && ctrl_q[`PIEB_CTRL_GLOBAL_BIT] &&
      ctrl_q[`PIEB_CTRL_GROUP_BIT] |=> irq_req[0])
      else $error("enabled timer one blocked");
   // timer one follows own flag only
   a_timer1_own: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ce && !src_flags[0] |=> !irq_req[0])
      else $error("timer one request without its flag");
   a_timer2_block: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ce && !en1_q[1] |=> !irq_req[1])
      else $error("disabled timer two requested");
   // global enable gates the core line
   a_global_gate: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ce && !ctrl_q[`PIEB_CTRL_GLOBAL_BIT] |=> !irq_core)
      else $error("core line raised without global enable");
   // control register write lands
   a_ctrl_write: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ce && wr_stb && wr_addr == AW'(`PIEB_OFF_CTRL) |=>
      ctrl_q == $past(wr_data[2:0]))
      else $error("control write lost");
   // mask register write lands
   a_mask_write: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ce && wr_stb && wr_addr == AW'(`PIEB_OFF_MASK) |=>
      mask_q == $past(wr_data[2:0]))
      else $error("mask write lost");
   // unmapped write sets its status bit, set beats clear
   a_unmapped_flag: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ce && wr_stb && wr_err |=> stat_q[2])
      else $error("unmapped write not flagged");
   // request rise sets its status bit
   a_rise_flag: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ce && any_req && !any_prev_q |=> stat_q[0])
      else $error("request rise not flagged");
   // request fall sets its status bit
   a_fall_flag: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ce && !any_req && any_prev_q |=> stat_q[1])
      else $error("request fall not flagged");
   // interrupt level follows status and mask
   a_irq_level: assert property (
      @(posedge aclk) disable iff (!aresetn)
      irq == |(stat_q & mask_q))
      else $error("interrupt line disagrees with status");
endmodule // pieb_top

// ==== tb/tb.sv ====
// Purpose: self-checking bench of the peripheral interrupt enable bank
// Assumes: AXI4-Lite timing as handed over, one clock, ce high except while the clock enable test drops it
// Notes: random stimulus from a fixed seed with fixed corner values
`timescale 1ns/1ps
`include "pieb_map.svh"
module tb
   import pieb_pkg::*;
;
logic aclk = 1'b0;
logic aresetn = 1'b0;
logic ce = 1'b1;
logic [11:0] s_awaddr = 12'h000;
logic s_awvalid = 1'b0;
logic s_awready;
logic [31:0] s_wdata = 32'h0;
logic [3:0] s_wstrb = 4'h0;
logic s_wvalid = 1'b0;
logic s_wready;
logic [1:0] s_bresp;
logic s_bvalid;
logic s_bready = 1'b0;
logic [11:0] s_araddr = 12'h000;
logic s_arvalid = 1'b0;
logic s_arready;
logic [31:0] s_rdata;
logic [1:0] s_rresp;
logic s_rvalid;
logic s_rready = 1'b0;
logic [23:0] src_flags = 24'h0;
logic [23:0] irq_req;
logic irq_core;
logic irq;
int bad_count = 0;
int n_compared = 0;

always #12.5 aclk = ~aclk;

pieb_top #(.PORT_PRESENT(1'b1), .AW(12)) DUT (
   .aclk(aclk), .aresetn(aresetn), .ce(ce),
   .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
   .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
   .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
   .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
   .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
   .s_rvalid(s_rvalid), .s_rready(s_rready), .src_flags(src_flags),
   .irq_req(irq_req), .irq_core(irq_core), .irq(irq)
);

////////////////////////////////////////////////////////////////////////////
task automatic end_sim();
   $display("counts: compared %0d bad %0d", n_compared, bad_count);
   if (bad_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
   end else begin
      $display("RESULT: FAIL");
   end
   $finish;
endtask

task automatic chk(input string what, input logic [31:0] got,
                   input logic [31:0] exp);
   n_compared++;
   if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
   end
endtask

task automatic hang();
   bad_count++;
   $display("BAD %0t wait ran out got %h exp %h", $time, 1'b0, 1'b1);
   end_sim();
endtask

// entered just after a rising edge; each channel dropped once taken
task automatic axw(input logic [11:0] a, input logic [31:0] d,
                   input logic [3:0] st, output logic [1:0] resp);
   logic aw_hs;
   logic w_hs;
   logic b_hs;
   s_awaddr <= a;
   s_awvalid <= 1'b1;
   s_wdata <= d;
   s_wstrb <= st;
   s_wvalid <= 1'b1;
   s_bready <= 1'b1;
   b_hs = 1'b0;
   for (int n = 0; n < 40 && !b_hs; n++) begin
      #1;
      aw_hs = s_awvalid && s_awready;
      w_hs = s_wvalid && s_wready;
      b_hs = s_bvalid && s_bready;
      resp = s_bresp;
      @(posedge aclk);
      if (aw_hs) s_awvalid <= 1'b0;
      if (w_hs) s_wvalid <= 1'b0;
      if (b_hs) s_bready <= 1'b0;
   end
   if (!b_hs) hang();
   @(posedge aclk);
endtask

task automatic axr(input logic [11:0] a, output logic [31:0] q,
                   output logic [1:0] resp);
   logic ar_hs;
   logic r_hs;
   s_araddr <= a;
   s_arvalid <= 1'b1;
   s_rready <= 1'b1;
   r_hs = 1'b0;
   for (int n = 0; n < 40 && !r_hs; n++) begin
      #1;
      ar_hs = s_arvalid && s_arready;
      r_hs = s_rvalid && s_rready;
      q = s_rdata;
      resp = s_rresp;
      @(posedge aclk);
      if (ar_hs) s_arvalid <= 1'b0;
      if (r_hs) s_rready <= 1'b0;
   end
   if (!r_hs) hang();
   @(posedge aclk);
endtask

task automatic wr(input logic [11:0] a, input logic [31:0] d);
   logic [1:0] r;
   axw(a, d, 4'hf, r);
   chk("bresp", {30'h0, r}, {30'h0, `PIEB_RESP_OKAY});
endtask

task automatic rdc(input string what, input logic [11:0] a,
                   input logic [31:0] e);
   logic [31:0] q;
   logic [1:0] r;
   axr(a, q, r);
   chk(what, q, e);
   chk("rresp", {30'h0, r}, {30'h0, `PIEB_RESP_OKAY});
endtask

function automatic logic [23:0] exp_req(input logic [23:0] f,
      input logic [23:0] en, input logic [2:0] c);
   logic perm;
   perm = c[`PIEB_CTRL_GLOBAL_BIT] &&
          (c[`PIEB_CTRL_PRIO_BIT] || c[`PIEB_CTRL_GROUP_BIT]);
   return f & en & {24{perm}};
endfunction

////////////////////////////////////////////////////////////////////////////
initial begin
   logic [31:0] d1;
   logic [31:0] d2;
   logic [31:0] d3;
   logic [23:0] f;
   logic [23:0] e;
   logic [2:0] c;
   logic [31:0] q;
   logic [1:0] r;
   pieb_byte_t b2;
   void'($urandom(32'h5aef23e3));
   repeat (3) @(posedge aclk);
   aresetn <= 1'b1;
   @(posedge aclk);
   for (int a = 0; a <= 24; a += 4) begin
      rdc("reset value", a[11:0], 32'h0);
   end
   $display("test reset values done");

   for (int i = 0; i < 8; i++) begin
      d1 = (i == 0) ? 32'hffffffff : $urandom;
      d2 = (i == 0) ? 32'hffffffff : $urandom;
      d3 = (i == 1) ? 32'h0 : $urandom;
      wr(`PIEB_OFF_EN1, d1);
      wr(`PIEB_OFF_EN2, d2);
      wr(`PIEB_OFF_EN3, d3);
      rdc("enable one", `PIEB_OFF_EN1, {24'h0, d1[7:0]});
      b2 = d2[7:0] & `PIEB_EN2_WMASK;
      rdc("enable two", `PIEB_OFF_EN2, {24'h0, b2});
      rdc("enable three", `PIEB_OFF_EN3, {24'h0, d3[7:0]});
   end
   axw(`PIEB_OFF_EN1, ~d1, 4'h0, r);
   chk("lane off bresp", {30'h0, r}, {30'h0, `PIEB_RESP_OKAY});
   rdc("lane off", `PIEB_OFF_EN1, {24'h0, d1[7:0]});
   $display("test register access done");

   for (int i = 0; i < 16; i++) begin
      c = i[2:0];
      e = 24'($urandom);
      if (i == 15) e = 24'hffffff;
      wr(`PIEB_OFF_EN1, {24'h0, e[7:0]});
      wr(`PIEB_OFF_EN2, {24'h0, e[15:8]});
      wr(`PIEB_OFF_EN3, {24'h0, e[23:16]});
      wr(`PIEB_OFF_CTRL, {29'h0, c});
      rdc("ctrl", `PIEB_OFF_CTRL, {29'h0, c});
      f = (i == 7) ? 24'h000003 : 24'($urandom);
      src_flags <= f;
      repeat (3) @(posedge aclk);
      #1;
      e[`PIEB_EN2_UNIMP_BIT + 8] = 1'b0;
      chk("irq_req", {8'h0, irq_req}, {8'h0, exp_req(f, e, c)});
      chk("irq_core", {31'h0, irq_core}, {31'h0, |exp_req(f, e, c)});
      rdc("any request", `PIEB_OFF_FLAG, {31'h0, |exp_req(f, e, c)});
   end
   $display("test request gating done");

   ce <= 1'b0;
   src_flags <= ~f;
   repeat (3) @(posedge aclk);
   #1;
   chk("frozen", {8'h0, irq_req}, {8'h0, exp_req(f, e, c)});
   @(posedge aclk);
   ce <= 1'b1;
   $display("test clock enable done");

   src_flags <= 24'h0;
   repeat (4) @(posedge aclk);
   wr(`PIEB_OFF_STAT, 32'h7);
   rdc("status clear", `PIEB_OFF_STAT, 32'h0);
   wr(`PIEB_OFF_MASK, 32'h4);
   axw(12'h01c, 32'hff, 4'hf, r);
   chk("unmapped bresp", {30'h0, r}, {30'h0, `PIEB_RESP_SLVERR});
   axr(12'hffc, q, r);
   chk("unmapped rresp", {30'h0, r}, {30'h0, `PIEB_RESP_SLVERR});
   rdc("status set", `PIEB_OFF_STAT, 32'h4);
   #1;
   chk("irq raised", {31'h0, irq}, 32'h1);
   wr(`PIEB_OFF_STAT, 32'h4);
   repeat (2) @(posedge aclk);
   #1;
   chk("irq cleared", {31'h0, irq}, 32'h0);
   @(posedge aclk);
   wr(`PIEB_OFF_MASK, 32'h0);
   axw(12'h020, 32'h1, 4'hf, r);
   chk("unmapped bresp two", {30'h0, r}, {30'h0, `PIEB_RESP_SLVERR});
   repeat (2) @(posedge aclk);
   #1;
   chk("irq masked", {31'h0, irq}, 32'h0);
   @(posedge aclk);
   rdc("status masked", `PIEB_OFF_STAT, 32'h4);
   $display("test unmapped and interrupt done");
   end_sim();
end
endmodule // tb
